// [tde_pkg.sv]
// Package for the tape completion, error and interrupt block
package tde_pkg;
  // AXI4-Lite register byte offsets
  localparam logic [7:0] TDE_CMD_OFS = 8'h00;
  localparam logic [7:0] TDE_ERR_OFS = 8'h04;
  localparam logic [7:0] TDE_STAT_OFS = 8'h08;
  localparam logic [7:0] TDE_CTL_OFS = 8'h0c;
  // Command register fields
  localparam int TDE_CMD_ERR_BIT = 15;
  localparam int TDE_CMD_IE_BIT = 6;
  localparam int TDE_CMD_FORCE_BIT = 0;
  localparam logic [15:0] TDE_CMD_RST = 16'h0000;
  // Control register: priority level field and vector field
  localparam int TDE_CTL_LVL_LSB = 0;
  localparam int TDE_CTL_VEC_LSB = 8;
  localparam logic [1:0] TDE_LVL_RST = 2'h1;
  localparam logic [6:0] TDE_VEC_RST = 7'h00;
  // Error register bit positions
  localparam int TDE_E_NXM = 0;
  localparam int TDE_E_BGL = 1;
  localparam int TDE_E_ILC = 2;
  localparam int TDE_E_BTE = 3;
  localparam int TDE_E_RLE = 4;
  localparam int TDE_E_CRE = 5;
  localparam int TDE_E_PAE = 6;
  localparam int TDE_E_EOF = 7;
  localparam int TDE_E_EOT = 8;
  localparam logic [8:0] TDE_ERR_RST = 9'h000;

  typedef enum logic [1:0] {TDE_IDLE, TDE_REQ, TDE_WAIT, TDE_MAST} tde_bus_e;

  // Transport and operation status from the controller
  typedef struct packed {
    logic space;
    logic space_rev;
    logic rewind;
    logic read_op;
    logic write_op;
    logic record_carry;
    logic end_record_check_strobe_delayed;
    logic transport_ready;
    logic transport_selected;
    logic off_line;
    logic write_locked;
    logic settle_down;
    logic gap_shutdown;
    logic read_strobe;
    logic crc_lrc_strobe;
    logic overflow;
    logic cyclic_check_error;
    logic vertical_parity_error;
    logic longitudinal_check_error;
    logic file_mark;
    logic end_of_tape;
    logic begin_of_tape;
    logic rewinding;
    logic local_rewind;
    logic start_strobe;
    logic cmd_reg_select;
    logic nonexistent_memory;
    logic grant_lost;
    logic npr_request;
  } tde_tape_s;

  // System bus interrupt pins
  typedef struct packed {
    logic [3:0] br;
    logic sack;
    logic bbsy;
    logic intr;
    logic [6:0] vec;
    logic bg_out;
  } tde_bus_s;
endpackage : tde_pkg

// [tde_ctrl.sv]
// Completion, error classification and vectored interrupt logic
// Overview of operation
// - Spacing completes on record count carry
// - Read/write completes on delayed check strobe
// - Error starts completion immediately
// - Done plus ready gives delayed done
// - Four cases skip waiting for ready
// - Error sets command bit fifteen
// - Four aborting errors raise error at once
// - Non-aborting errors wait for check strobe
// - Busy select or lost selection: illegal
// - Start unselected or write locked: illegal
// - Strobe in gap or settle: bad tape
// - Data strobe after overflow: length error
// - Strobe with cyclic error: check error
// - Strobe with parity error: parity error
// - File mark sets end of file
// - End of tape error except rewind or reverse space
// - Enabled interrupt on three event kinds
// - New-command set pulse gated by cycle in progress
// - Request on jumper level four to seven
// - Sack on grant, wait bus free
// - Interrupt with vector, cleared by ssyn
//
// The placing of the registers and register access over AXI4-Lite were chosen for this implementation.
module tde_ctrl
  import tde_pkg::*;
(
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire tde_tape_s tape_in,
  input wire logic bg_in,
  input wire logic bbsy_in,
  input wire logic ssyn_in,
  output tde_bus_s bus_out,
  output logic done_out,
  output logic done_delayed_out,
  output logic set_control_ready_out,
  output logic err_out,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  typedef struct packed {
    logic [15:0] cmd;
    logic [8:0] errs;
    logic [1:0] lvl;
    logic [6:0] vec;
    logic done;
    logic done_dly;
    logic control_ready_delayed;
    logic bus_request_pending;
    logic interrupt_master;
    tde_bus_e bst;
    logic sel_q;
    logic bot_q;
    logic rw_done_q;
    tde_bus_s bus;
    logic set_cr;
    logic aw_ok;
    logic w_ok;
    logic [7:0] awa;
    logic [31:0] wd;
    logic [3:0] ws;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } tde_state_s;

  tde_state_s st;
  tde_state_s next_st;

  logic [8:0] new_err;
  logic err_now;
  logic abort_any;
  logic get_new_cmd;
  logic set_int;
  logic cmd_reg_low_write;
  logic wr_go;
  logic rd_go;

  always_comb begin
    next_st = st;
    next_st.set_cr = 1'b0;
    new_err = '0;
    // Busy means no ready-delayed; register touches then are illegal
    new_err[TDE_E_ILC] = (tape_in.cmd_reg_select
      && !st.control_ready_delayed)
      || (st.sel_q && !tape_in.transport_selected
      && !tape_in.off_line && !st.control_ready_delayed);
    if (tape_in.start_strobe && (!tape_in.transport_selected
        || (tape_in.write_op && tape_in.write_locked))) begin
      new_err[TDE_E_ILC] = 1'b1;
    end
    new_err[TDE_E_NXM] = tape_in.nonexistent_memory;
    new_err[TDE_E_BGL] = tape_in.grant_lost;
    abort_any = st.errs[TDE_E_NXM] || st.errs[TDE_E_BGL]
      || st.errs[TDE_E_ILC] || new_err[TDE_E_NXM]
      || new_err[TDE_E_BGL] || new_err[TDE_E_ILC];
    new_err[TDE_E_BTE] = tape_in.read_strobe && !abort_any
      && (tape_in.settle_down || tape_in.gap_shutdown);
    new_err[TDE_E_RLE] = tape_in.read_strobe && tape_in.overflow
      && !tape_in.crc_lrc_strobe;
    new_err[TDE_E_CRE] = tape_in.read_strobe
      && tape_in.cyclic_check_error
      && (tape_in.read_op || tape_in.write_op);
    new_err[TDE_E_PAE] = tape_in.read_strobe
      && (tape_in.vertical_parity_error
      || tape_in.longitudinal_check_error)
      && (tape_in.read_op || tape_in.write_op);
    new_err[TDE_E_EOF] = tape_in.file_mark;
    new_err[TDE_E_EOT] = tape_in.end_of_tape && !tape_in.rewind
      && !tape_in.space_rev;
    next_st.errs = st.errs | new_err;
    // Aborting errors flag at once; others only with the check strobe
    err_now = |next_st.errs[TDE_E_BTE:TDE_E_NXM];
    if (tape_in.end_record_check_strobe_delayed
        && |next_st.errs[TDE_E_EOT:TDE_E_RLE]) begin
      err_now = 1'b1;
    end
    if (err_now) begin
      next_st.cmd[TDE_CMD_ERR_BIT] = 1'b1;
    end
    next_st.sel_q = tape_in.transport_selected;
    next_st.bot_q = tape_in.begin_of_tape;
    // A new start clears completion; a same-cycle completion still wins
    if (tape_in.start_strobe && !new_err[TDE_E_ILC]) begin
      next_st.done = 1'b0;
      next_st.done_dly = 1'b0;
      next_st.control_ready_delayed = 1'b0;
    end
    if (tape_in.space ? tape_in.record_carry
        : tape_in.end_record_check_strobe_delayed) begin
      next_st.done = 1'b1;
    end
    if (err_now) begin
      next_st.done = 1'b1;
    end
    get_new_cmd = 1'b0;
    if ((st.done && tape_in.transport_ready && !st.done_dly)
        || (next_st.errs[TDE_E_ILC] && !st.done_dly)
        || (tape_in.begin_of_tape && !st.bot_q
        && (tape_in.space_rev || tape_in.rewind))
        || (st.sel_q && !tape_in.transport_selected)
        || tape_in.local_rewind) begin
      get_new_cmd = 1'b1;
      next_st.done_dly = 1'b1;
      next_st.set_cr = 1'b1;
      next_st.control_ready_delayed = 1'b1;
    end
    // AXI4-Lite slave: address and data accepted in either order
    wr_go = st.aw_ok && st.w_ok && !st.bvalid;
    if (s_axi_awvalid && !st.aw_ok) begin
      next_st.aw_ok = 1'b1;
      next_st.awa = s_axi_awaddr[7:0];
    end
    if (s_axi_wvalid && !st.w_ok) begin
      next_st.w_ok = 1'b1;
      next_st.wd = s_axi_wdata;
      next_st.ws = s_axi_wstrb;
    end
    cmd_reg_low_write = wr_go && st.awa == TDE_CMD_OFS && st.ws[0];
    if (wr_go) begin
      next_st.aw_ok = 1'b0;
      next_st.w_ok = 1'b0;
      next_st.bvalid = 1'b1;
      next_st.bresp = 2'b00;
      if (st.awa == TDE_CMD_OFS) begin
        if (st.ws[0]) begin
          next_st.cmd[7:0] = st.wd[7:0];
          next_st.cmd[TDE_CMD_FORCE_BIT] = 1'b0;
        end
        if (st.ws[1]) begin
          // Error bit stays set if set by hardware this cycle
          next_st.cmd[15:8] = st.wd[15:8] | {err_now, 7'h00};
        end
      end else if (st.awa == TDE_ERR_OFS) begin
        // Write one to clear; a new error in the same cycle wins
        next_st.errs = (st.errs & ~st.wd[8:0]) | new_err;
      end else if (st.awa == TDE_CTL_OFS) begin
        if (st.ws[0]) begin
          next_st.lvl = st.wd[TDE_CTL_LVL_LSB +: 2];
        end
        if (st.ws[1]) begin
          next_st.vec = st.wd[TDE_CTL_VEC_LSB +: 7];
        end
      end else if (st.awa != TDE_STAT_OFS) begin
        next_st.bresp = 2'b10;
      end
    end
    if (st.bvalid && s_axi_bready) begin
      next_st.bvalid = 1'b0;
    end
    rd_go = s_axi_arvalid && !st.rvalid;
    if (rd_go) begin
      next_st.rvalid = 1'b1;
      next_st.rresp = 2'b00;
      next_st.rdata = '0;
      if (s_axi_araddr[7:0] == TDE_CMD_OFS) begin
        next_st.rdata[15:0] = st.cmd;
      end else if (s_axi_araddr[7:0] == TDE_ERR_OFS) begin
        next_st.rdata[8:0] = st.errs;
      end else if (s_axi_araddr[7:0] == TDE_STAT_OFS) begin
        next_st.rdata[5:0] = {st.interrupt_master,
          st.bus_request_pending, st.control_ready_delayed,
          st.done_dly, st.done, st.cmd[TDE_CMD_ERR_BIT]};
      end else if (s_axi_araddr[7:0] == TDE_CTL_OFS) begin
        next_st.rdata[TDE_CTL_LVL_LSB +: 2] = st.lvl;
        next_st.rdata[TDE_CTL_VEC_LSB +: 7] = st.vec;
      end else begin
        next_st.rresp = 2'b10;
      end
    end
    if (st.rvalid && s_axi_rready) begin
      next_st.rvalid = 1'b0;
    end
    // Interrupt set pulse; one request at a time
    set_int = (get_new_cmd && st.bst == TDE_IDLE)
      || (tape_in.begin_of_tape && !st.bot_q
      && st.control_ready_delayed && tape_in.rewinding)
      || (cmd_reg_low_write && st.wd[TDE_CMD_FORCE_BIT]);
    next_st.bus.br = '0;
    next_st.bus.sack = 1'b0;
    next_st.bus.bbsy = 1'b0;
    next_st.bus.intr = 1'b0;
    next_st.bus.vec = '0;
    case (st.bst)
      TDE_IDLE: begin
        if (next_st.bus_request_pending) begin
          next_st.bst = TDE_REQ;
        end
      end
      TDE_REQ: begin
        next_st.bus.br[st.lvl] = 1'b1;
        if (bg_in && !tape_in.npr_request) begin
          next_st.bst = TDE_WAIT;
          next_st.bus.br = '0;
          next_st.bus.sack = 1'b1;
        end
      end
      TDE_WAIT: begin
        next_st.bus.sack = 1'b1;
        // Mastership only after grant has dropped and bus is free
        if (!bg_in && !bbsy_in) begin
          next_st.bst = TDE_MAST;
          next_st.interrupt_master = 1'b1;
          next_st.bus.sack = 1'b0;
          next_st.bus.bbsy = 1'b1;
          next_st.bus.intr = 1'b1;
          next_st.bus.vec = st.vec;
        end
      end
      TDE_MAST: begin
        next_st.bus.bbsy = 1'b1;
        next_st.bus.intr = 1'b1;
        next_st.bus.vec = st.vec;
        if (ssyn_in) begin
          next_st.bst = TDE_IDLE;
          next_st.bus_request_pending = 1'b0;
          next_st.interrupt_master = 1'b0;
          next_st.bus.bbsy = 1'b0;
          next_st.bus.intr = 1'b0;
          next_st.bus.vec = '0;
        end
      end
      default: next_st.bst = TDE_IDLE;
    endcase
    // After the bus cycle so a request arriving with ssyn is not lost
    if (set_int && next_st.cmd[TDE_CMD_IE_BIT]
        && st.cmd[TDE_CMD_IE_BIT]) begin
      next_st.bus_request_pending = 1'b1;
    end
    // Direct-transfer requests outrank interrupt requests
    next_st.bus.bg_out = bg_in && !tape_in.npr_request
      && (st.interrupt_master || !st.bus_request_pending);
  end

  always_ff @(posedge mclk_in) begin
    if (rst_in) begin
      st <= '0;
      st.cmd <= TDE_CMD_RST;
      st.errs <= TDE_ERR_RST;
      st.lvl <= TDE_LVL_RST;
      st.vec <= TDE_VEC_RST;
      st.control_ready_delayed <= 1'b1;
      st.bst <= TDE_IDLE;
    end else begin
      st <= next_st;
    end
  end

  assign bus_out = st.bus;
  assign done_out = st.done;
  assign done_delayed_out = st.done_dly;
  assign set_control_ready_out = st.set_cr;
  assign err_out = st.cmd[TDE_CMD_ERR_BIT];
  assign s_axi_awready = !st.aw_ok;
  assign s_axi_wready = !st.w_ok;
  assign s_axi_bvalid = st.bvalid;
  assign s_axi_bresp = st.bresp;
  assign s_axi_arready = !st.rvalid;
  assign s_axi_rvalid = st.rvalid;
  assign s_axi_rdata = st.rdata;
  assign s_axi_rresp = st.rresp;

endmodule : tde_ctrl

// [tde_ctrl_props.sv]
// Concurrent checks on the tape completion and interrupt block
module tde_ctrl_props
  import tde_pkg::*;
(
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire tde_tape_s tape_in,
  input wire logic bg_in,
  input wire logic bbsy_in,
  input wire logic ssyn_in,
  input wire tde_bus_s bus_out,
  input wire logic done_out,
  input wire logic done_delayed_out,
  input wire logic err_out
);
  default clocking cb @(posedge mclk_in);
  endclocking
  default disable iff (rst_in);

  space_done_a: assert property (
    tape_in.space && tape_in.record_carry |-> ##[1:2] done_out)
    else $error("spacing end missed");
  rw_done_a: assert property (
    !tape_in.space && tape_in.end_record_check_strobe_delayed
    |-> ##[1:2] done_out) else $error("record end missed");
  abort_err_a: assert property (
    tape_in.nonexistent_memory || tape_in.grant_lost
    |-> ##[1:2] err_out) else $error("abort error missed");
  err_done_a: assert property (
    $rose(err_out) |-> ##[0:2] done_out) else $error("no done on error");
  ready_dly_a: assert property (
    done_out && tape_in.transport_ready |-> ##[0:2] done_delayed_out)
    else $error("delayed done missed");
  sack_grant_a: assert property (
    $rose(bus_out.sack) |-> $past(bg_in)) else $error("sack without grant");
  bbsy_free_a: assert property (
    $rose(bus_out.bbsy) |-> !$past(bbsy_in) && !$past(bg_in))
    else $error("bus taken while busy");
  ssyn_clear_a: assert property (
    bus_out.intr && ssyn_in |-> ##[1:2] !bus_out.intr)
    else $error("interrupt not cleared");
  grant_pass_a: assert property (
    bus_out.bg_out |-> $past(bg_in) && !$past(tape_in.npr_request)
    && ($past(bus_out.bbsy) || $past(bus_out.br) == 4'h0))
    else $error("grant passed wrongly");
  level_hot_a: assert property (
    bus_out.br != 4'h0 |-> $onehot(bus_out.br)) else $error("bad level");

  cover property (bus_out.intr && ssyn_in);
  cover property (bus_out.bg_out);
  cover property ($rose(err_out));
endmodule : tde_ctrl_props

bind tde_ctrl tde_ctrl_props u_props (.mclk_in, .rst_in, .tape_in, .bg_in,
  .bbsy_in, .ssyn_in, .bus_out, .done_out, .done_delayed_out, .err_out);

// [tde_bus_host.sv]
// Behavioural processor side of the interrupt handshake
module tde_bus_host
  import tde_pkg::*;
(
  input wire logic mclk_in,
  input wire logic rst_in,
  input wire tde_bus_s bus_in,
  input wire logic slow_in,
  output logic bg_out = 1'b0,
  output logic ssyn_out = 1'b0,
  output logic [6:0] vec_out,
  output logic [3:0] lvl_out,
  output logic [7:0] ints_out
);
  logic [2:0] dly;
  always @(posedge mclk_in) begin
    if (rst_in) begin
      bg_out <= 1'b0;
      ssyn_out <= 1'b0;
      ints_out <= 8'h00;
      dly <= 3'h0;
    end else begin
      if (bus_in.sack) begin
        bg_out <= 1'b0;
        dly <= 3'h0;
      end else if (bus_in.br != 4'h0 && !bus_in.bbsy && !bg_out) begin
        // Slow mode delays the grant to stress the request hold
        dly <= dly + 3'h1;
        if (dly >= (slow_in ? 3'h5 : 3'h0)) begin
          bg_out <= 1'b1;
          lvl_out <= bus_in.br;
        end
      end
      if (bus_in.intr && !ssyn_out) begin
        ssyn_out <= 1'b1;
        vec_out <= bus_in.vec;
        ints_out <= ints_out + 8'h01;
      end else if (!bus_in.intr) begin
        ssyn_out <= 1'b0;
      end
    end
  end
endmodule : tde_bus_host

// [tde_ctrl_test.sv]
// Self-checking bench for the tape completion and interrupt block
module tde_ctrl_test import tde_pkg::*; ();
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_in = 1'b0;
  logic rst_in = 1'b1;
  logic ext_bg = 1'b0;
  logic bbsy_in = 1'b0;
  logic slow = 1'b0;
  logic hbg, bg_in, ssyn_in;
  tde_tape_s tape_in = '0;
  tde_bus_s bus_out;
  logic done_out, done_delayed_out, set_control_ready_out, err_out;
  logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0;
  logic [3:0] s_axi_wstrb = '0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rrs, brs;
  logic [31:0] s_axi_rdata, rdv;
  logic [6:0] hvec;
  logic [3:0] hlvl;
  logic [7:0] ints;
  tde_tape_s b, l, p, q;
  logic [8:0] exp_tab [13] = '{9'h001, 9'h002, 9'h004, 9'h004, 9'h004,
    9'h008, 9'h010, 9'h020, 9'h040, 9'h040, 9'h080, 9'h100, 9'h000};
  int bad_count = 0;
  int n_checks = 0;
  int cyc = 0;

  assign bg_in = hbg | ext_bg;
  tde_ctrl DUT (.mclk_in, .rst_in, .tape_in, .bg_in, .bbsy_in, .ssyn_in,
    .bus_out, .done_out, .done_delayed_out, .set_control_ready_out,
    .err_out, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready);
  tde_bus_host HOST (.mclk_in, .rst_in, .bus_in(bus_out), .slow_in(slow),
    .bg_out(hbg), .ssyn_out(ssyn_in), .vec_out(hvec), .lvl_out(hlvl),
    .ints_out(ints));

  initial begin
    forever #2.5 mclk_in = ~mclk_in;
  end

  task give_verdict();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict

  // A hung handshake must still end in the report
  always @(posedge mclk_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      bad_count++;
      give_verdict();
    end
  end

  task chk(input logic [31:0] g, input logic [31:0] x);
    n_checks++;
    if (g !== x) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, g, x);
    end
  endtask : chk

  task tick(input int n);
    repeat (n) @(posedge mclk_in);
  endtask : tick

  task do_reset();
    @(posedge mclk_in);
    rst_in <= 1'b1;
    tick(2);
    rst_in <= 1'b0;
    tick(1);
  endtask : do_reset

  task pulse(input tde_tape_s m);
    @(posedge mclk_in);
    tape_in <= tde_tape_s'(tape_in | m);
    @(posedge mclk_in);
    tape_in <= tde_tape_s'(tape_in & ~m);
  endtask : pulse

  task wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    int n;
    logic pa, pd;
    n = 0;
    pa = 1'b1;
    pd = 1'b1;
    @(posedge mclk_in);
    s_axi_awaddr <= {24'h0, a};
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while ((pa || pd || s_axi_bvalid !== 1'b1) && n < 100) begin
      @(posedge mclk_in);
      n++;
      if (pa && s_axi_awready === 1'b1) begin
        pa = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (pd && s_axi_wready === 1'b1) begin
        pd = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end
    brs = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (n >= 100) bad_count++;
  endtask : wr

  task rd(input logic [7:0] a);
    int n;
    logic pa;
    n = 0;
    pa = 1'b1;
    @(posedge mclk_in);
    s_axi_araddr <= {24'h0, a};
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    while ((pa || s_axi_rvalid !== 1'b1) && n < 100) begin
      @(posedge mclk_in);
      n++;
      if (pa && s_axi_arready === 1'b1) begin
        pa = 1'b0;
        s_axi_arvalid <= 1'b0;
      end
    end
    rdv = s_axi_rdata;
    rrs = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (n >= 100) bad_count++;
  endtask : rd

  task wait_ints(input logic [7:0] k);
    for (int i = 0; i < 300 && ints < k; i++) tick(1);
  endtask : wait_ints

  initial begin
    b = '0;
    b.transport_selected = 1'b1;
    b.transport_ready = 1'b1;
    b.read_op = 1'b1;
    do_reset();
    rd(TDE_CTL_OFS);
    chk(rdv, 32'h0000_0001);
    rd(8'h20);
    chk(rrs, 2'b10);
    wr(8'h20, 32'h0000_0000, 4'hf);
    chk(brs, 2'b10);
    // Level index 2 selects the third request line, vector 2a
    wr(TDE_CTL_OFS, 32'h0000_2a02, 4'h3);
    chk(brs, 2'b00);
    wr(TDE_CMD_OFS, 32'h0000_0040, 4'h3);
    tape_in <= b;
    ext_bg <= 1'b1;
    tick(2);
    chk(bus_out.bg_out, 1);
    tape_in.npr_request <= 1'b1;
    tick(2);
    chk(bus_out.bg_out, 0);
    ext_bg <= 1'b0;
    tape_in.npr_request <= 1'b0;
    tape_in.space <= 1'b1;
    tape_in.transport_ready <= 1'b0;
    p = '0;
    p.record_carry = 1'b1;
    pulse(p);
    tick(2);
    chk(done_out, 1);
    chk(done_delayed_out, 0);
    tape_in.transport_ready <= 1'b1;
    wait_ints(1);
    chk(done_delayed_out, 1);
    chk(ints, 1);
    chk(hvec, 7'h2a);
    chk(hlvl, 4'h4);
    bbsy_in <= 1'b1;
    slow <= 1'b1;
    wr(TDE_CMD_OFS, 32'h0000_0041, 4'h1);
    for (int i = 0; i < 300 && bus_out.sack !== 1'b1; i++) tick(1);
    tick(4);
    chk(bus_out.bbsy, 0);
    bbsy_in <= 1'b0;
    wait_ints(2);
    chk(ints, 2);
    for (int i = 0; i < 13; i++) begin
      l = b;
      l.transport_ready = 1'b0;
      p = '0;
      q = '0;
      p.read_strobe = i inside {[5:9]};
      case (i)
        0: p.nonexistent_memory = 1'b1;
        1: p.grant_lost = 1'b1;
        2: begin
          p.start_strobe = 1'b1;
          q.cmd_reg_select = 1'b1;
        end
        3: begin
          l.transport_selected = 1'b0;
          p.start_strobe = 1'b1;
        end
        4: begin
          l.write_op = 1'b1;
          l.write_locked = 1'b1;
          p.start_strobe = 1'b1;
        end
        5: l.settle_down = 1'b1;
        6: l.overflow = 1'b1;
        7: l.cyclic_check_error = 1'b1;
        8: l.vertical_parity_error = 1'b1;
        9: l.longitudinal_check_error = 1'b1;
        10: l.file_mark = 1'b1;
        default: l.end_of_tape = 1'b1;
      endcase
      l.rewind = (i == 12);
      l.read_op = (i != 12);
      tape_in <= l;
      do_reset();
      pulse(p);
      pulse(q);
      tick(2);
      rd(TDE_ERR_OFS);
      chk(rdv, {23'h0, exp_tab[i]});
      p = '0;
      p.end_record_check_strobe_delayed = 1'b1;
      pulse(p);
      tick(3);
      chk(err_out, |exp_tab[i]);
      chk(done_out, 1);
      chk(done_delayed_out, exp_tab[i][2]);
      rd(TDE_CMD_OFS);
      chk(rdv[15], |exp_tab[i]);
    end
    for (int i = 0; i < 3; i++) begin
      l = b;
      l.transport_ready = 1'b0;
      l.space_rev = (i == 1);
      p = '0;
      p.local_rewind = (i == 0);
      p.begin_of_tape = (i == 1);
      // Dropping an already set select bit models a deselection
      p.transport_selected = (i == 2);
      tape_in <= l;
      do_reset();
      pulse(p);
      for (int k = 0; k < 4 && set_control_ready_out !== 1'b1; k++) tick(1);
      chk(set_control_ready_out, 1);
      tick(1);
      chk(set_control_ready_out, 0);
      chk(done_delayed_out, 1);
    end
    l = b;
    l.rewinding = 1'b1;
    tape_in <= l;
    do_reset();
    wr(TDE_CMD_OFS, 32'h0000_0040, 4'h1);
    p = '0;
    p.begin_of_tape = 1'b1;
    pulse(p);
    wait_ints(1);
    chk(ints, 1);
    chk(done_delayed_out, 0);
    give_verdict();
  end
endmodule : tde_ctrl_test
